// file: verilog/kmgc_regs.svh
`ifndef KMGC_REGS_SVH
`define KMGC_REGS_SVH

// ==========================================
// Register indices, byte address = 4 * index
`define KMGC_IDX_PULLUP      7'h4E
`define KMGC_IDX_FUNC_DIR    7'h4F
`define KMGC_IDX_KEY_MASK    7'h50
`define KMGC_IDX_COL_MASK    7'h51
`define KMGC_IDX_PENDING     7'h10
`define KMGC_IDX_STATUS      7'h11
`define KMGC_IDX_LINE_OUT    7'h52
`define KMGC_IDX_LINE_IN     7'h53
`define KMGC_IDX_IRQ_STAT    7'h60
`define KMGC_IDX_IRQ_MASK    7'h61

// ==========================================
// Field positions
`define KMGC_ALT_SEL_MSB     15
`define KMGC_ALT_SEL_LSB     8
`define KMGC_DIR_MSB         7
`define KMGC_DIR_LSB         0
`define KMGC_COL_MSB         15
`define KMGC_COL_LSB         12
`define KMGC_PU_MSB          15
`define KMGC_PU_LSB          8
`define KMGC_IRQ_KEY_BIT     0
`define KMGC_IRQ_LINE_BIT    1
`define KMGC_ROWS            4
`define KMGC_ADDR_LSB        2

// ==========================================
// Reset values
`define KMGC_RST_WORD        16'h0000
`define KMGC_RST_LINE        8'h00
`define KMGC_RST_COL         4'h0
`define KMGC_RST_IRQ         2'h0
`define KMGC_RST_DATA        32'h0000_0000

`endif

// file: verilog/kmgc_pkg.sv
package kmgc_pkg;
   typedef logic [15:0] kmgc_word_t;
   typedef logic [7:0]  kmgc_line_t;
   typedef logic [1:0]  kmgc_irq_t;
   typedef enum {
      KMGC_SEL_NONE,
      KMGC_SEL_PULLUP,
      KMGC_SEL_FUNC_DIR,
      KMGC_SEL_KEY_MASK,
      KMGC_SEL_COL_MASK,
      KMGC_SEL_PENDING,
      KMGC_SEL_STATUS,
      KMGC_SEL_LINE_OUT,
      KMGC_SEL_LINE_IN,
      KMGC_SEL_IRQ_STAT,
      KMGC_SEL_IRQ_MASK
   } kmgc_reg_sel_t;
endpackage : kmgc_pkg

// file: verilog/kmgc_sync.sv
`timescale 1ns/1ps
module kmgc_sync #(
   parameter int WIDTH = 8
) (
   input  wire logic             I_CLK_SYS,
   input  wire logic             I_RESET,
   input  wire logic [WIDTH-1:0] i_d,
   output logic      [WIDTH-1:0] o_q
);
   // ==========================================
   // Two stages per bit; first stage feeds only the second
   genvar b;
   generate
      for (b = 0; b < WIDTH; b++) begin : g_bit
         logic meta_reg;
         logic sync_reg;
         always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
            if (I_RESET) begin
               meta_reg <= 1'b0;
               sync_reg <= 1'b0;
            end else begin
               meta_reg <= i_d[b];
               sync_reg <= meta_reg;
            end
         end
         assign o_q[b] = sync_reg;
      end
   endgenerate
endmodule : kmgc_sync

// file: verilog/kmgc_cfg_regs.sv
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "kmgc_regs.svh"

module kmgc_cfg_regs (
   input  wire logic                I_CLK_SYS,
   input  wire logic                I_RESET,
   input  wire logic [8:0]          I_AVS_ADDRESS,
   input  wire logic                I_AVS_READ,
   input  wire logic                I_AVS_WRITE,
   input  wire logic [31:0]         I_AVS_WRITEDATA,
   input  wire logic [3:0]          I_AVS_BYTEENABLE,
   output logic      [31:0]         O_AVS_READDATA,
   output logic                     O_AVS_WAITREQUEST,
   input  wire kmgc_pkg::kmgc_word_t I_SCAN_KEYS,
   input  wire logic                I_SCAN_VALID,
   input  wire kmgc_pkg::kmgc_line_t I_SCAN_LINE_OUT,
   input  wire kmgc_pkg::kmgc_line_t I_SCAN_LINE_OE,
   input  wire kmgc_pkg::kmgc_line_t I_LINE_IN,
   output kmgc_pkg::kmgc_line_t      O_LINE_OUT,
   output kmgc_pkg::kmgc_line_t      O_LINE_OE,
   output kmgc_pkg::kmgc_line_t      O_LINE_SYNC,
   output kmgc_pkg::kmgc_line_t      O_KEYPAD_SEL,
   output kmgc_pkg::kmgc_line_t      O_PULLUP_EN,
   output kmgc_pkg::kmgc_word_t      O_STATUS_DATA,
   output kmgc_pkg::kmgc_word_t      O_PENDING_DATA,
   output logic                     O_IRQ
);
   import kmgc_pkg::*;

   localparam int LINES = 8;
   localparam int COLS  = 4;

   // ==========================================
   // Pin input synchroniser
   kmgc_line_t    line_sync;

   kmgc_sync #(
      .WIDTH (LINES)
   ) u_line_sync (
      .I_CLK_SYS (I_CLK_SYS),
      .I_RESET   (I_RESET),
      .i_d       (I_LINE_IN),
      .o_q       (line_sync)
   );

   // ==========================================
   // State declarations
   logic          ack_reg;
   logic          ack_next;
   logic [31:0]   rdata_reg;
   logic [31:0]   rdata_next;

   kmgc_line_t    pullup_dis_reg;
   kmgc_line_t    pullup_dis_next;
   kmgc_word_t    func_dir_reg;
   kmgc_word_t    func_dir_next;
   kmgc_word_t    key_mask_reg;
   kmgc_word_t    key_mask_next;
   logic [3:0]    col_mask_reg;
   logic [3:0]    col_mask_next;
   kmgc_line_t    line_out_reg;
   kmgc_line_t    line_out_next;
   kmgc_irq_t     irq_mask_reg;
   kmgc_irq_t     irq_mask_next;

   kmgc_word_t    status_reg;
   kmgc_word_t    status_next;
   kmgc_word_t    pending_reg;
   kmgc_word_t    pending_next;
   kmgc_irq_t     irq_stat_reg;
   kmgc_irq_t     irq_stat_next;
   kmgc_line_t    line_prev_reg;
   kmgc_line_t    line_prev_next;

   kmgc_reg_sel_t sel;
   logic [6:0]    idx;
   logic          word_ok;
   logic          wr_fire;
   logic [15:0]   wmask;
   logic [15:0]   wdata;
   kmgc_word_t    rd_word;
   kmgc_word_t    col_keys;
   kmgc_line_t    alt_sel;
   kmgc_line_t    dir;
   kmgc_irq_t     events;
   logic          bus_req;
   logic          rd_take;
   kmgc_word_t    key_live;
   kmgc_word_t    status_hold;
   kmgc_line_t    line_change;
   kmgc_line_t    gpio_out;
   kmgc_line_t    gpio_oe;

   // ==========================================
   // Address decode
   assign idx     = I_AVS_ADDRESS[8:`KMGC_ADDR_LSB];
   assign word_ok = (I_AVS_ADDRESS[`KMGC_ADDR_LSB-1:0] == 2'h0);
   assign wdata   = I_AVS_WRITEDATA[15:0];
   assign wmask   = {{8{I_AVS_BYTEENABLE[1]}}, {8{I_AVS_BYTEENABLE[0]}}};

   always_comb begin
      sel = KMGC_SEL_NONE;
      if (word_ok) begin
         unique case (idx)
            `KMGC_IDX_PULLUP:   sel = KMGC_SEL_PULLUP;
            `KMGC_IDX_FUNC_DIR: sel = KMGC_SEL_FUNC_DIR;
            `KMGC_IDX_KEY_MASK: sel = KMGC_SEL_KEY_MASK;
            `KMGC_IDX_COL_MASK: sel = KMGC_SEL_COL_MASK;
            `KMGC_IDX_PENDING:  sel = KMGC_SEL_PENDING;
            `KMGC_IDX_STATUS:   sel = KMGC_SEL_STATUS;
            `KMGC_IDX_LINE_OUT: sel = KMGC_SEL_LINE_OUT;
            `KMGC_IDX_LINE_IN:  sel = KMGC_SEL_LINE_IN;
            `KMGC_IDX_IRQ_STAT: sel = KMGC_SEL_IRQ_STAT;
            `KMGC_IDX_IRQ_MASK: sel = KMGC_SEL_IRQ_MASK;
            default:            sel = KMGC_SEL_NONE;
         endcase
      end
   end

   // ==========================================
   // Read mux, reserved bits zero
   always_comb begin
      rd_word = `KMGC_RST_WORD;
      unique case (sel)
         KMGC_SEL_PULLUP: begin
            rd_word[`KMGC_PU_MSB:`KMGC_PU_LSB] = pullup_dis_reg;
         end
         KMGC_SEL_FUNC_DIR: begin
            rd_word = func_dir_reg;
         end
         KMGC_SEL_KEY_MASK: begin
            rd_word = key_mask_reg;
         end
         KMGC_SEL_COL_MASK: begin
            rd_word[`KMGC_COL_MSB:`KMGC_COL_LSB] = col_mask_reg;
         end
         KMGC_SEL_PENDING: begin
            rd_word = pending_reg;
         end
         KMGC_SEL_STATUS: begin
            rd_word = status_reg;
         end
         KMGC_SEL_LINE_OUT: begin
            rd_word[LINES-1:0] = line_out_reg;
         end
         KMGC_SEL_LINE_IN: begin
            rd_word[LINES-1:0] = line_sync;
         end
         KMGC_SEL_IRQ_STAT: begin
            rd_word[1:0] = irq_stat_reg;
         end
         KMGC_SEL_IRQ_MASK: begin
            rd_word[1:0] = irq_mask_reg;
         end
         KMGC_SEL_NONE: begin
            rd_word = `KMGC_RST_WORD;
         end
      endcase
   end

   // ==========================================
   // Avalon handshake: one wait cycle, then answer
   assign bus_req = I_AVS_READ | I_AVS_WRITE;
   // Read data captured in the wait cycle so it stands when waitrequest drops
   assign rd_take = I_AVS_READ & ~ack_reg;

   always_comb begin
      ack_next   = bus_req & ~ack_reg;
      rdata_next = rdata_reg;
      if (rd_take) begin
         rdata_next = {16'h0000, rd_word};
      end
   end

   always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
      if (I_RESET) begin
         ack_reg   <= 1'b0;
         rdata_reg <= `KMGC_RST_DATA;
      end else begin
         ack_reg   <= ack_next;
         rdata_reg <= rdata_next;
      end
   end

   assign O_AVS_WAITREQUEST = bus_req & ~ack_reg;
   assign O_AVS_READDATA    = rdata_reg;
   // Write lands on the same edge the master sees waitrequest low
   assign wr_fire           = I_AVS_WRITE & ack_reg;

   // ==========================================
   // Configuration registers
   always_comb begin
      pullup_dis_next = pullup_dis_reg;
      func_dir_next   = func_dir_reg;
      key_mask_next   = key_mask_reg;
      col_mask_next   = col_mask_reg;
      line_out_next   = line_out_reg;
      irq_mask_next   = irq_mask_reg;
      if (wr_fire) begin
         unique case (sel)
            KMGC_SEL_PULLUP: begin
               // Low byte is dropped; software should write it as zero
               pullup_dis_next = (pullup_dis_reg & ~wmask[`KMGC_PU_MSB:`KMGC_PU_LSB])
                  | (wdata[`KMGC_PU_MSB:`KMGC_PU_LSB]
                     & wmask[`KMGC_PU_MSB:`KMGC_PU_LSB]);
            end
            KMGC_SEL_FUNC_DIR: begin
               func_dir_next = (func_dir_reg & ~wmask) | (wdata & wmask);
            end
            KMGC_SEL_KEY_MASK: begin
               key_mask_next = (key_mask_reg & ~wmask) | (wdata & wmask);
            end
            KMGC_SEL_COL_MASK: begin
               col_mask_next = (col_mask_reg & ~wmask[`KMGC_COL_MSB:`KMGC_COL_LSB])
                  | (wdata[`KMGC_COL_MSB:`KMGC_COL_LSB]
                     & wmask[`KMGC_COL_MSB:`KMGC_COL_LSB]);
            end
            KMGC_SEL_LINE_OUT: begin
               line_out_next = (line_out_reg & ~wmask[LINES-1:0])
                  | (wdata[LINES-1:0] & wmask[LINES-1:0]);
            end
            KMGC_SEL_IRQ_MASK: begin
               irq_mask_next = (irq_mask_reg & ~wmask[1:0]) | (wdata[1:0] & wmask[1:0]);
            end
            default: begin
               irq_mask_next = irq_mask_reg;
            end
         endcase
      end
   end

   always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
      if (I_RESET) begin
         pullup_dis_reg <= `KMGC_RST_LINE;
         func_dir_reg   <= `KMGC_RST_WORD;
         key_mask_reg   <= `KMGC_RST_WORD;
         col_mask_reg   <= `KMGC_RST_COL;
         line_out_reg   <= `KMGC_RST_LINE;
         irq_mask_reg   <= `KMGC_RST_IRQ;
      end else begin
         pullup_dis_reg <= pullup_dis_next;
         func_dir_reg   <= func_dir_next;
         key_mask_reg   <= key_mask_next;
         col_mask_reg   <= col_mask_next;
         line_out_reg   <= line_out_next;
         irq_mask_reg   <= irq_mask_next;
      end
   end

   // ==========================================
   // Column mask spread over its four keys
   genvar c;
   generate
      for (c = 0; c < COLS; c++) begin : g_col
         assign col_keys[c*`KMGC_ROWS +: `KMGC_ROWS] = {`KMGC_ROWS{col_mask_reg[c]}};
      end
   endgenerate

   // ==========================================
   // Line function, direction and pullup
   assign alt_sel = func_dir_reg[`KMGC_ALT_SEL_MSB:`KMGC_ALT_SEL_LSB];
   assign dir     = func_dir_reg[`KMGC_DIR_MSB:`KMGC_DIR_LSB];
   // Open collector only ever pulls low when the pullup is off
   assign gpio_out = line_out_reg & ~pullup_dis_reg;
   assign gpio_oe  = dir & (~pullup_dis_reg | ~line_out_reg);

   genvar n;
   generate
      for (n = 0; n < LINES; n++) begin : g_line
         // Keypad lines stay with the scanner until software claims them
         always_comb begin
            if (alt_sel[n]) begin
               O_LINE_OUT[n] = gpio_out[n];
               O_LINE_OE[n]  = gpio_oe[n];
            end else begin
               O_LINE_OUT[n] = I_SCAN_LINE_OUT[n];
               O_LINE_OE[n]  = I_SCAN_LINE_OE[n];
            end
         end
      end
   endgenerate

   assign O_KEYPAD_SEL = ~alt_sel;
   assign O_PULLUP_EN  = ~pullup_dis_reg;
   assign O_LINE_SYNC  = line_sync;

   // ==========================================
   // Scan data, events and interrupt status
   // Key mask only freezes status; pending and interrupt follow the column mask
   assign key_live    = I_SCAN_KEYS & ~col_keys;
   assign status_hold = col_keys | key_mask_reg;
   // Only lines set up as GPIO inputs raise a change event
   assign line_change = (line_sync ^ line_prev_reg) & alt_sel & ~dir;

   always_comb begin
      events         = `KMGC_RST_IRQ;
      status_next    = status_reg;
      pending_next   = pending_reg;
      line_prev_next = line_sync;
      if (I_SCAN_VALID) begin
         pending_next = (pending_reg & col_keys) | key_live;
         status_next  = (status_reg & status_hold)
                        | (I_SCAN_KEYS & ~status_hold);
         events[`KMGC_IRQ_KEY_BIT] = |key_live;
      end
      events[`KMGC_IRQ_LINE_BIT] = |line_change;
      irq_stat_next = irq_stat_reg;
      if (wr_fire && (sel == KMGC_SEL_IRQ_STAT)) begin
         irq_stat_next = irq_stat_reg & ~(wdata[1:0] & wmask[1:0]);
      end
      // Set beats clear in the same cycle
      irq_stat_next = irq_stat_next | events;
   end

   always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
      if (I_RESET) begin
         status_reg    <= `KMGC_RST_WORD;
         pending_reg   <= `KMGC_RST_WORD;
         irq_stat_reg  <= `KMGC_RST_IRQ;
         line_prev_reg <= `KMGC_RST_LINE;
      end else begin
         status_reg    <= status_next;
         pending_reg   <= pending_next;
         irq_stat_reg  <= irq_stat_next;
         line_prev_reg <= line_prev_next;
      end
   end

   assign O_STATUS_DATA  = status_reg;
   assign O_PENDING_DATA = pending_reg;
   assign O_IRQ          = |(irq_stat_reg & irq_mask_reg);

endmodule : kmgc_cfg_regs

// file: sim/kmgc_cfg_regs_chk.sv
`timescale 1ns/1ps
module kmgc_cfg_regs_chk (
   input  wire logic                 I_CLK_SYS,
   input  wire logic                 I_RESET,
   input  wire logic [8:0]           I_AVS_ADDRESS,
   input  wire logic                 I_AVS_READ,
   input  wire logic                 I_AVS_WRITE,
   input  wire logic [31:0]          I_AVS_WRITEDATA,
   input  wire logic [3:0]           I_AVS_BYTEENABLE,
   input  wire logic [31:0]          O_AVS_READDATA,
   input  wire logic                 O_AVS_WAITREQUEST,
   input  wire kmgc_pkg::kmgc_word_t I_SCAN_KEYS,
   input  wire logic                 I_SCAN_VALID,
   input  wire kmgc_pkg::kmgc_line_t I_SCAN_LINE_OUT,
   input  wire kmgc_pkg::kmgc_line_t I_SCAN_LINE_OE,
   input  wire kmgc_pkg::kmgc_line_t O_LINE_OUT,
   input  wire kmgc_pkg::kmgc_line_t O_LINE_OE,
   input  wire kmgc_pkg::kmgc_line_t O_KEYPAD_SEL,
   input  wire kmgc_pkg::kmgc_line_t O_PULLUP_EN,
   input  wire kmgc_pkg::kmgc_word_t O_STATUS_DATA,
   input  wire kmgc_pkg::kmgc_word_t O_PENDING_DATA
);
   default clocking cb @(posedge I_CLK_SYS); endclocking
   default disable iff (I_RESET);
   // ==========================================
   // Bus steps
   sequence s_req;
      (I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST;
   endsequence
   sequence s_wr(a);
      I_AVS_WRITE && !O_AVS_WAITREQUEST && I_AVS_ADDRESS == a && I_AVS_BYTEENABLE[1];
   endsequence
   // ==========================================
   // Properties
   property p_func_sel;
      s_wr(9'h13C) |=> O_KEYPAD_SEL == ~$past(I_AVS_WRITEDATA[15:8]);
   endproperty
   property p_pullup;
      s_wr(9'h138) |=> O_PULLUP_EN == ~$past(I_AVS_WRITEDATA[15:8]);
   endproperty
   property p_keypad_pass;
      (((O_LINE_OE ^ I_SCAN_LINE_OE) | (O_LINE_OUT ^ I_SCAN_LINE_OUT)) & O_KEYPAD_SEL) == 8'h00;
   endproperty
   property p_hold_noscan;
      !I_SCAN_VALID |=> $stable(O_PENDING_DATA) && $stable(O_STATUS_DATA);
   endproperty
   // A changed key bit must carry the scanned level, never a stale one
   property p_scan_take;
      I_SCAN_VALID |=> ((((O_STATUS_DATA ^ $past(O_STATUS_DATA))
                          & (O_STATUS_DATA ^ $past(I_SCAN_KEYS)))
                         | ((O_PENDING_DATA ^ $past(O_PENDING_DATA))
                          & (O_PENDING_DATA ^ $past(I_SCAN_KEYS)))) == 16'h0000);
   endproperty
   AST_ONE_WAIT: assert property (s_req |=> !O_AVS_WAITREQUEST)
      else $error("waitrequest held past one cycle");
   AST_IDLE_READY: assert property (!(I_AVS_READ || I_AVS_WRITE) |-> !O_AVS_WAITREQUEST)
      else $error("waitrequest high while idle");
   AST_RD_UPPER: assert property (O_AVS_READDATA[31:16] == 16'h0000)
      else $error("read data upper half not zero");
   AST_FUNC_SEL: assert property (p_func_sel)
      else $error("line function select not taken");
   AST_PULLUP: assert property (p_pullup)
      else $error("pullup control not taken");
   AST_KEYPAD_PASS: assert property (p_keypad_pass)
      else $error("keypad line not driven by scanner");
   AST_OPEN_COLL: assert property ((O_LINE_OUT & ~O_KEYPAD_SEL & ~O_PULLUP_EN) == 8'h00)
      else $error("open collector line driven high");
   AST_HOLD_NOSCAN: assert property (p_hold_noscan)
      else $error("key data changed without scan");
   AST_SCAN_TAKE: assert property (p_scan_take)
      else $error("status took a value other than the scan");
endmodule : kmgc_cfg_regs_chk

bind kmgc_cfg_regs kmgc_cfg_regs_chk u_chk (.*);

// file: sim/kmgc_host.sv
`timescale 1ns/1ps
module kmgc_host (
   input  wire logic        I_CLK_SYS,
   input  wire logic        i_wait,
   output logic      [8:0]  o_addr,
   output logic             o_rd,
   output logic             o_wr,
   output logic      [31:0] o_wdata,
   output logic      [3:0]  o_be
);
   initial begin
      o_addr  = 9'h000;
      o_rd    = 1'b0;
      o_wr    = 1'b0;
      o_wdata = 32'h0000_0000;
      o_be    = 4'h0;
   end
   // ==========================================
   // One transfer; gap of at least one edge avoids re-raising in the same step
   task automatic xfer(input logic rd, input logic [8:0] a, input logic [15:0] d,
                       input logic [3:0] be);
      repeat ($urandom_range(1, 3)) @(posedge I_CLK_SYS);
      o_addr  <= a;
      o_rd    <= rd;
      o_wr    <= !rd;
      o_wdata <= {16'h0000, d};
      o_be    <= be;
      do @(posedge I_CLK_SYS); while (i_wait);
      o_rd    <= 1'b0;
      o_wr    <= 1'b0;
      o_addr  <= ~a;
      o_wdata <= ~{16'h0000, d};
   endtask : xfer
endmodule : kmgc_host

// file: sim/kmgc_cfg_regs_test.sv
`timescale 1ns/1ps
module kmgc_cfg_regs_test;
   import kmgc_pkg::*;
   logic clk = 1'b0, rst = 1'b1, rd, wr, wreq, sv = 1'b0, irq;
   logic [8:0] addr;
   logic [31:0] wdata, rdata;
   logic [3:0] be;
   kmgc_word_t keys = 16'h0000, stat, pend, d;
   kmgc_line_t slo = 8'h5A, sle = 8'h3C, lin = 8'h00, lout, loe, lsync, ksel, puen;
   logic [31:0] exp_q[$];
   int n_mismatch = 0, num_checks = 0;
   logic [8:0] adr[4] = '{9'h138, 9'h13C, 9'h140, 9'h144};
   kmgc_word_t msk[4] = '{16'hFF00, 16'hFFFF, 16'hFFFF, 16'hF000};
   always #2.5 clk = ~clk;
   kmgc_host u_kmgc_host (.I_CLK_SYS(clk), .i_wait(wreq), .o_addr(addr), .o_rd(rd),
      .o_wr(wr), .o_wdata(wdata), .o_be(be));
   kmgc_cfg_regs u_kmgc_cfg_regs (.I_CLK_SYS(clk), .I_RESET(rst), .I_AVS_ADDRESS(addr),
      .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdata), .I_AVS_BYTEENABLE(be),
      .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(wreq), .I_SCAN_KEYS(keys),
      .I_SCAN_VALID(sv), .I_SCAN_LINE_OUT(slo), .I_SCAN_LINE_OE(sle), .I_LINE_IN(lin),
      .O_LINE_OUT(lout), .O_LINE_OE(loe), .O_LINE_SYNC(lsync), .O_KEYPAD_SEL(ksel),
      .O_PULLUP_EN(puen), .O_STATUS_DATA(stat), .O_PENDING_DATA(pend), .O_IRQ(irq));
   // ==========================================
   // Checking
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] e);
      num_checks++;
      if (seen !== e) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, e, seen);
      end
   endtask : check
   task automatic test_done;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : test_done
   always @(posedge clk) begin
      if (!rst && rd && !wreq) check("readdata", rdata, exp_q.pop_front());
   end
   task automatic rd_exp(input logic [8:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      u_kmgc_host.xfer(1'b1, a, 16'h0000, 4'h3);
   endtask : rd_exp
   task automatic wr_reg(input logic [8:0] a, input kmgc_word_t v);
      u_kmgc_host.xfer(1'b0, a, v, 4'h3);
   endtask : wr_reg
   task automatic scan(input kmgc_word_t k);
      keys <= k;
      sv   <= 1'b1;
      @(posedge clk);
      sv   <= 1'b0;
      @(posedge clk);
      #1;
   endtask : scan
   // ==========================================
   // Tests
   initial begin
      void'($urandom(93));
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      foreach (adr[i]) rd_exp(adr[i], 32'h0000_0000);
      check("keypad_sel", ksel, 8'hFF);
      for (int r = 0; r < 4; r++) begin
         foreach (adr[i]) begin
            d = 16'($urandom);
            if (i == 0) d[7:0] = 8'h00; // Host keeps low byte zero
            wr_reg(adr[i], d);
            rd_exp(adr[i], {16'h0000, d & msk[i]});
         end
      end
      rd_exp(9'h000, 32'h0000_0000);
      wr_reg(9'h13C, 16'hF030);
      wr_reg(9'h148, 16'h00FF);
      wr_reg(9'h138, 16'h2000);
      #1;
      check("keypad_sel", ksel, 8'h0F);
      check("line_oe", loe, 8'h1C);
      check("line_out", lout, 8'hDA);
      check("pullup_en", puen, 8'hDF);
      wr_reg(9'h148, 16'h00DF);
      #1;
      check("line_oe low drive", loe, 8'h3C);
      lin <= 8'hA5;
      repeat (4) @(posedge clk);
      check("line_sync", lsync, 32'h0000_00A5);
      rd_exp(9'h14C, 32'h0000_00A5);
      rd_exp(9'h180, 32'h0000_0002);
      wr_reg(9'h140, 16'h0001);
      wr_reg(9'h144, 16'h2000);
      wr_reg(9'h184, 16'h0001);
      wr_reg(9'h180, 16'h0003);
      scan(16'h00F0);
      check("irq masked column", irq, 1'b0);
      check("pending masked column", pend, 16'h0000);
      check("status masked column", stat, 16'h0000);
      scan(16'hFFFF);
      check("pending", pend, 16'hFF0F);
      check("status", stat, 16'hFF0E);
      check("irq raised", irq, 1'b1);
      rd_exp(9'h040, 32'h0000_FF0F);
      rd_exp(9'h044, 32'h0000_FF0E);
      wr_reg(9'h180, 16'h0001);
      #1;
      check("irq cleared", irq, 1'b0);
      wr_reg(9'h184, 16'h0000);
      scan(16'h0001);
      check("pending key", pend, 16'h0001);
      check("status key masked", stat, 16'h0000);
      check("irq disabled", irq, 1'b0);
      rd_exp(9'h180, 32'h0000_0001);
      u_kmgc_host.xfer(1'b0, 9'h140, 16'hABCD, 4'h2);
      rd_exp(9'h140, 32'h0000_AB01);
      rst <= 1'b1;
      @(posedge clk);
      #1;
      check("keypad_sel reset", ksel, 8'hFF);
      @(posedge clk);
      rst <= 1'b0;
      rd_exp(9'h13C, 32'h0000_0000);
      rd_exp(9'h140, 32'h0000_0000);
      @(posedge clk);
      check("read queue", exp_q.size(), 32'h0000_0000);
      test_done();
   end
   initial begin
      #200000;
      n_mismatch++;
      test_done();
   end
endmodule : kmgc_cfg_regs_test
